// ==== rtl/hac_actuator_config_regs.sv ====
// actuator configuration registers, impedance readback and resonant period timing
`timescale 1ns/1ps
module hac_actuator_config_regs
  import hac_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  // register access port from the serial control interface
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // top-level configuration input
  input wire logic accel_en,
  // calculated impedance from the calibration logic
  input wire logic imp_update,
  input wire logic [IMP_W-1:0] imp_value,
  // waveform and overdrive requests from the drive logic
  input wire logic wave_valid,
  input wire logic [7:0] wave_sample,
  input wire logic overdrive_valid,
  input wire logic [7:0] overdrive_level,
  // configuration values to the drive logic
  output logic [PERIOD_W-1:0] resonant_period_value,
  output logic period_pulse,
  output logic drive_phase,
  output logic [CURRENT_W-1:0] max_current_code,
  output logic [FACTOR_W-1:0] voltage_current_factor,
  output logic [7:0] full_scale_code,
  output logic level_valid,
  output logic [7:0] level_code,
  output logic drive_valid,
  output logic [FACTOR_W-1:0] drive_level,
  output logic od_valid,
  output logic [7:0] od_level
);

  // register address classes
  // the read-only class lets writes be dropped while reads still decode
  typedef enum logic [1:0] {
    HAC_ACC_NONE = 2'b00,
    HAC_ACC_RW = 2'b01,
    HAC_ACC_RO = 2'b10
  } hac_access_t;

  // classify an address; used by the write qualify only, the read mux decodes on its own
  function automatic hac_access_t hac_classify(input logic [ADDR_W-1:0] a);
    hac_access_t c;
    c = HAC_ACC_NONE;
    case (a)
      OFS_PERIOD_HIGH, OFS_PERIOD_LOW, OFS_NOMINAL_V, OFS_ABSOLUTE_V,
      OFS_MAX_CURRENT, OFS_FACTOR_HIGH, OFS_FACTOR_LOW: begin
        c = HAC_ACC_RW;
      end
      OFS_IMP_HIGH, OFS_IMP_LOW: begin
        c = HAC_ACC_RO;
      end
      default: begin
        c = HAC_ACC_NONE;
      end
    endcase
    return c;
  endfunction : hac_classify

  // configuration registers and impedance readback
  logic [7:0] period_high_byte_q;
  logic [PERIOD_LOW_W-1:0] period_low_field_q;
  logic [7:0] nominal_code_q;
  logic [7:0] absolute_code_q;
  logic [CURRENT_W-1:0] max_current_code_q;
  logic [7:0] conversion_high_byte_q;
  logic [7:0] conversion_low_byte_q;
  logic [7:0] imp_high_q;
  logic [IMP_LOW_W-1:0] imp_low_q;
  // write qualify and read mux
  logic wr_ok;
  logic [DATA_W-1:0] rdata_d;

  // writes land only on read-write registers; read-only and unmapped are dropped
  // read-only fields belong to the calibration logic, a host write must not disturb them
  assign wr_ok = reg_wr && (hac_classify(reg_addr) == HAC_ACC_RW);

  // resonant period high byte
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      period_high_byte_q <= RST_PERIOD_HIGH;
    end else if (wr_ok && (reg_addr == OFS_PERIOD_HIGH)) begin
      period_high_byte_q <= reg_wdata;
    end
  end

  // resonant period low field, bit 7 not stored
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      period_low_field_q <= RST_PERIOD_LOW;
    end else if (wr_ok && (reg_addr == OFS_PERIOD_LOW)) begin
      period_low_field_q <= reg_wdata[PERIOD_LOW_W-1:0];
    end
  end

  // nominal voltage rating code
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      nominal_code_q <= RST_NOMINAL_V;
    end else if (wr_ok && (reg_addr == OFS_NOMINAL_V)) begin
      nominal_code_q <= reg_wdata;
    end
  end

  // absolute maximum voltage rating code
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      absolute_code_q <= RST_ABSOLUTE_V;
    end else if (wr_ok && (reg_addr == OFS_ABSOLUTE_V)) begin
      absolute_code_q <= reg_wdata;
    end
  end

  // maximum current code, upper three bits not stored
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      max_current_code_q <= RST_MAX_CURRENT;
    end else if (wr_ok && (reg_addr == OFS_MAX_CURRENT)) begin
      max_current_code_q <= reg_wdata[CURRENT_W-1:0];
    end
  end

  // conversion factor high byte
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      conversion_high_byte_q <= RST_FACTOR_HIGH;
    end else if (wr_ok && (reg_addr == OFS_FACTOR_HIGH)) begin
      conversion_high_byte_q <= reg_wdata;
    end
  end

  // conversion factor low byte
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      conversion_low_byte_q <= RST_FACTOR_LOW;
    end else if (wr_ok && (reg_addr == OFS_FACTOR_LOW)) begin
      conversion_low_byte_q <= reg_wdata;
    end
  end

  // impedance readback, loaded only by the calibration logic
  // both parts load at one edge, so a read never sees a torn value
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      imp_high_q <= RST_IMP_HIGH;
      imp_low_q <= RST_IMP_LOW;
    end else if (imp_update) begin
      imp_high_q <= imp_value[IMP_W-1:IMP_LOW_W];
      imp_low_q <= imp_value[IMP_LOW_W-1:0];
    end
  end

  // read data mux; narrow fields sit low, upper bits read zero
  always_comb begin
    rdata_d = UNMAPPED_READ;
    case (reg_addr)
      OFS_PERIOD_HIGH: begin
        rdata_d = period_high_byte_q;
      end
      OFS_PERIOD_LOW: begin
        rdata_d = {1'b0, period_low_field_q};
      end
      OFS_NOMINAL_V: begin
        rdata_d = nominal_code_q;
      end
      OFS_ABSOLUTE_V: begin
        rdata_d = absolute_code_q;
      end
      OFS_MAX_CURRENT: begin
        rdata_d = {3'h0, max_current_code_q};
      end
      OFS_FACTOR_HIGH: begin
        rdata_d = conversion_high_byte_q;
      end
      OFS_FACTOR_LOW: begin
        rdata_d = conversion_low_byte_q;
      end
      OFS_IMP_HIGH: begin
        rdata_d = imp_high_q;
      end
      OFS_IMP_LOW: begin
        rdata_d = {6'h00, imp_low_q};
      end
      default: begin
        rdata_d = UNMAPPED_READ;
      end
    endcase
  end

  // read answer one cycle after the strobe
  // a write in the same cycle lands at this edge, so the read shows the old value
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
    end
  end

  // combined values seen by the drive logic
  // pairs update one write at a time; the mixed value is visible in between
  assign resonant_period_value = {period_high_byte_q, period_low_field_q};
  assign voltage_current_factor = {conversion_high_byte_q, conversion_low_byte_q};
  assign max_current_code = max_current_code_q;

  // period unit tick: fractional accumulator of clock periods against the unit
  // the unit is not a whole number of clocks, so a plain divider would drift;
  // ticks come 66 or 67 clocks apart and average out to the exact unit
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(CLK_PERIOD_PS);
  localparam logic [ACC_W-1:0] ACC_UNIT = ACC_W'(PERIOD_UNIT_PS);
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_sum;
  logic unit_tick;
  assign acc_sum = acc_q + ACC_STEP;
  assign unit_tick = (acc_sum >= ACC_UNIT);

  // accumulator keeps the remainder so the mean tick spacing is exact
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      acc_q <= '0;
    end else if (unit_tick) begin
      acc_q <= acc_sum - ACC_UNIT;
    end else begin
      acc_q <= acc_sum;
    end
  end

  // count units through one resonant period
  logic [PERIOD_W-1:0] unit_cnt_q;
  logic [PERIOD_W-1:0] unit_next;
  logic [PERIOD_W-1:0] half_point;
  logic period_zero;
  logic period_end;
  // count after the coming tick, shared by the end and half-period tests
  assign unit_next = unit_cnt_q + 15'h0001;
  // a zero period is a disabled timer, not a one-unit period
  assign period_zero = (resonant_period_value == '0);
  assign half_point = {1'b0, resonant_period_value[PERIOD_W-1:1]};
  // greater-or-equal so a shortened period restarts at once
  // instead of running on until the counter wraps
  assign period_end = unit_tick && !period_zero && (unit_next >= resonant_period_value);

  // unit counter wraps at the period end; a zero period holds it idle
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      unit_cnt_q <= '0;
    end else if (period_zero) begin
      unit_cnt_q <= '0;
    end else if (period_end) begin
      unit_cnt_q <= '0;
    end else if (unit_tick) begin
      unit_cnt_q <= unit_next;
    end
  end

  // period pulse and drive phase: phase high in the second half period
  // a zero period parks the phase low together with the counter
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      period_pulse <= 1'b0;
      drive_phase <= 1'b0;
    end else begin
      period_pulse <= period_end;
      if (period_end || period_zero) begin
        drive_phase <= 1'b0;
      end else if (unit_tick && (unit_next == half_point)) begin
        drive_phase <= 1'b1;
      end
    end
  end

  // waveform scaling, overdrive clamp and level-times-factor drive level
  // acceleration enable comes from the top-level configuration register outside
  hac_level_shaper #(
    .SHIFT(FACTOR_SHIFT)
  ) u_shaper (
    .core_clk(core_clk),
    .rstn(rstn),
    .accel_en(accel_en),
    .nominal_code(nominal_code_q),
    .absolute_code(absolute_code_q),
    .factor(voltage_current_factor),
    .wave_valid(wave_valid),
    .wave_sample(wave_sample),
    .overdrive_valid(overdrive_valid),
    .overdrive_level(overdrive_level),
    .full_scale_code(full_scale_code),
    .level_valid(level_valid),
    .level_code(level_code),
    .drive_valid(drive_valid),
    .drive_level(drive_level),
    .od_valid(od_valid),
    .od_level(od_level)
  );

endmodule : hac_actuator_config_regs

// ==== rtl/hac_pkg.sv ====
// constants for the haptic actuator configuration register group
// Function
// - period value is high byte times 128 plus low
// - each period count lasts 1333.32 ns
// - period resets to 0x21 and 0x4f
// - nominal voltage code unsigned 8-bit, reset 0x5a
// - acceleration on: nominal code sets full scale
// - acceleration on: overdrive clamped to absolute code
// - acceleration off: absolute code sets full scale
// - 5-bit max current code, reset 0x17
// - factor is high byte times 256 plus low
// - factor translates impedance into voltage drive level; the code multiplies the waveform level by it, impedance is only read back
// - impedance readback read-only, high field resets zero
// - impedance low field is 2 bits next register
package hac_pkg;

  // register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [7:0] OFS_PERIOD_HIGH = 8'h0a;
  localparam logic [7:0] OFS_PERIOD_LOW = 8'h0b;
  localparam logic [7:0] OFS_NOMINAL_V = 8'h0c;
  localparam logic [7:0] OFS_ABSOLUTE_V = 8'h0d;
  localparam logic [7:0] OFS_MAX_CURRENT = 8'h0e;
  localparam logic [7:0] OFS_FACTOR_HIGH = 8'h0f;
  localparam logic [7:0] OFS_FACTOR_LOW = 8'h10;
  localparam logic [7:0] OFS_IMP_HIGH = 8'h11;
  localparam logic [7:0] OFS_IMP_LOW = 8'h12;

  // field widths
  localparam int PERIOD_LOW_W = 7;
  localparam int PERIOD_W = 15;
  localparam int CURRENT_W = 5;
  localparam int FACTOR_W = 16;
  localparam int IMP_LOW_W = 2;
  localparam int IMP_W = 10;

  // reset values
  localparam logic [7:0] RST_PERIOD_HIGH = 8'h21;
  localparam logic [6:0] RST_PERIOD_LOW = 7'h4f;
  localparam logic [7:0] RST_NOMINAL_V = 8'h5a;
  localparam logic [7:0] RST_ABSOLUTE_V = 8'h78;
  localparam logic [4:0] RST_MAX_CURRENT = 5'h17;
  localparam logic [7:0] RST_FACTOR_HIGH = 8'h01;
  localparam logic [7:0] RST_FACTOR_LOW = 8'h0d;
  localparam logic [7:0] RST_IMP_HIGH = 8'h00;
  localparam logic [1:0] RST_IMP_LOW = 2'h0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // timing: period unit and clock rate
  localparam real PERIOD_UNIT_NS = 1333.32;
  localparam int CLK_FREQ_MHZ = 50;
  localparam int CLK_PERIOD_PS = 1000000 / CLK_FREQ_MHZ;
  localparam int PERIOD_UNIT_PS = int'(PERIOD_UNIT_NS * 1000.0);
  localparam int ACC_W = 21;

  // shift applied after multiplying level by the conversion factor
  localparam int FACTOR_SHIFT = 8;

endpackage : hac_pkg

// ==== rtl/hac_level_shaper.sv ====
// waveform full-scale scaling, overdrive clamp and voltage drive level
`timescale 1ns/1ps
module hac_level_shaper
  import hac_pkg::*;
#(
  parameter int SHIFT = FACTOR_SHIFT
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic accel_en,
  input wire logic [7:0] nominal_code,
  input wire logic [7:0] absolute_code,
  input wire logic [FACTOR_W-1:0] factor,
  input wire logic wave_valid,
  input wire logic [7:0] wave_sample,
  input wire logic overdrive_valid,
  input wire logic [7:0] overdrive_level,
  output logic [7:0] full_scale_code,
  output logic level_valid,
  output logic [7:0] level_code,
  output logic drive_valid,
  output logic [FACTOR_W-1:0] drive_level,
  output logic od_valid,
  output logic [7:0] od_level
);

  logic [7:0] fs_d;
  logic [16:0] scaled;
  logic [23:0] product;

  // full-scale selection by acceleration mode
  always_comb begin
    fs_d = accel_en ? nominal_code : absolute_code;
  end

  // (sample+1)*fs/256 maps 0xff exactly onto full scale, 0 onto 0
  assign scaled = ({8'h00, wave_sample} + 17'h00001) * {9'h000, fs_d};
  // level times factor gives the drive level
  assign product = {16'h0000, level_code} * {8'h00, factor};

  // registered full-scale code
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      full_scale_code <= 8'h00;
    end else begin
      full_scale_code <= fs_d;
    end
  end

  // waveform level stage, then drive level one cycle later
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      level_valid <= 1'b0;
      level_code <= 8'h00;
      drive_valid <= 1'b0;
      drive_level <= '0;
    end else begin
      level_valid <= wave_valid;
      if (wave_valid) begin
        level_code <= scaled[15:8];
      end
      drive_valid <= level_valid;
      if (level_valid) begin
        drive_level <= product[SHIFT +: FACTOR_W];
      end
    end
  end

  // overdrive clamp applies only with acceleration enabled
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      od_valid <= 1'b0;
      od_level <= 8'h00;
    end else begin
      od_valid <= overdrive_valid;
      if (overdrive_valid) begin
        if (accel_en && (overdrive_level > absolute_code)) begin
          od_level <= absolute_code;
        end else begin
          od_level <= overdrive_level;
        end
      end
    end
  end

endmodule : hac_level_shaper

// ==== testbench/hac_config_regs_properties.sv ====
// concurrent checks on the actuator configuration register ports
`timescale 1ns/1ps
module hac_config_checker
  import hac_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic accel_en,
  input wire logic wave_valid,
  input wire logic overdrive_valid,
  input wire logic [7:0] overdrive_level,
  input wire logic [PERIOD_W-1:0] resonant_period_value,
  input wire logic [CURRENT_W-1:0] max_current_code,
  input wire logic [FACTOR_W-1:0] voltage_current_factor,
  input wire logic level_valid,
  input wire logic drive_valid,
  input wire logic od_valid,
  input wire logic [7:0] od_level
);
  // one clock domain, reset disables everything
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // shadow of the absolute voltage code, kept from the register writes
  logic [7:0] abs_shadow_q;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      abs_shadow_q <= RST_ABSOLUTE_V;
    end else if (reg_wr && (reg_addr == OFS_ABSOLUTE_V)) begin
      abs_shadow_q <= reg_wdata;
    end
  end

  // read answer follows every read strobe, and nothing else
  read_answer_a: assert property (reg_rvalid == $past(reg_rd))
    else $error("read answer not one cycle after strobe");
  // period high byte lands above the seven low bits
  period_high_a: assert property (reg_wr && reg_addr == OFS_PERIOD_HIGH |=>
    resonant_period_value[14:7] == $past(reg_wdata)) else $error("period high byte misplaced");
  period_low_a: assert property (reg_wr && reg_addr == OFS_PERIOD_LOW |=>
    resonant_period_value[6:0] == $past(reg_wdata[6:0])) else $error("period low field misplaced");
  // unused top bit of the low field reads back as zero
  low_bit_clear_a: assert property (reg_rd && reg_addr == OFS_PERIOD_LOW |=>
    reg_rdata[7] == 1'b0) else $error("period low bit 7 not zero");
  current_code_a: assert property (reg_wr && reg_addr == OFS_MAX_CURRENT |=>
    max_current_code == $past(reg_wdata[4:0])) else $error("current code not stored");
  factor_high_a: assert property (reg_wr && reg_addr == OFS_FACTOR_HIGH |=>
    voltage_current_factor[15:8] == $past(reg_wdata)) else $error("factor high byte misplaced");
  // overdrive is clamped to the absolute code while acceleration is on
  od_clamp_a: assert property (overdrive_valid && accel_en |=> od_valid &&
    od_level == (($past(overdrive_level) > $past(abs_shadow_q)) ? $past(abs_shadow_q) : $past(overdrive_level)))
    else $error("overdrive clamp wrong");
  // without acceleration the request passes unchanged
  od_pass_a: assert property (overdrive_valid && !accel_en |=> od_valid &&
    od_level == $past(overdrive_level)) else $error("overdrive passed wrongly");
  level_chain_a: assert property (wave_valid |=> level_valid ##1 drive_valid)
    else $error("drive level chain broken");
endmodule : hac_config_checker

bind hac_actuator_config_regs hac_config_checker i_chk (.*);

// ==== testbench/hac_actuator_model.sv ====
// behavioural actuator absorbing the levels from the output stage
`timescale 1ns/1ps
module hac_actuator_model
  import hac_pkg::*;
(
  input wire logic core_clk,
  input wire logic drive_valid,
  input wire logic [FACTOR_W-1:0] drive_level,
  input wire logic od_valid,
  input wire logic [7:0] od_level,
  input wire logic period_pulse,
  output logic [FACTOR_W-1:0] seen_drive,
  output logic [7:0] seen_od,
  output int pulses = 0
);
  // latch each applied level and count resonant periods
  always @(posedge core_clk) begin
    if (drive_valid) begin
      seen_drive <= drive_level;
    end
    if (od_valid) begin
      seen_od <= od_level;
    end
    if (period_pulse) begin
      pulses <= pulses + 1;
    end
  end
endmodule : hac_actuator_model

// ==== testbench/haptic_actuator_config_regs_tb.sv ====
// self-checking bench for the actuator configuration registers
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module haptic_actuator_config_regs_tb;
  import hac_pkg::*;
  logic core_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, accel_en = 1'b1;
  logic imp_update = 1'b0, wave_valid = 1'b0, overdrive_valid = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, wave_sample = 8'h00, overdrive_level = 8'h00;
  logic [9:0] imp_value = 10'h000;
  logic [7:0] reg_rdata, full_scale_code, level_code, od_level, seen_od;
  logic [14:0] resonant_period_value;
  logic [4:0] max_current_code;
  logic [15:0] voltage_current_factor, drive_level, seen_drive;
  logic reg_rvalid, period_pulse, drive_phase, level_valid, drive_valid, od_valid;
  int bad_count = 0, tests_run = 0, cycles = 0, pulses, n, m;
  localparam logic [7:0] RST_TAB [9] = '{8'h21, 8'h4f, 8'h5a, 8'h78, 8'h17, 8'h01, 8'h0d, 8'h00, 8'h00};
  localparam logic [7:0] PAT_TAB [9] = '{8'ha5, 8'h25, 8'ha5, 8'ha5, 8'h05, 8'ha5, 8'ha5, 8'h00, 8'h00};

  hac_actuator_config_regs i_dut (.*);
  hac_actuator_model i_act (.*);

  always #10 core_clk = ~core_clk;

  // cycle ceiling against hangs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b0;
    `CHK(reg_rvalid, 1'b1)
    `CHK(reg_rdata, e)
  endtask : rd

  // one waveform sample and one overdrive request in the same cycle
  task automatic wave(input logic [7:0] s, input logic [7:0] o, input logic [7:0] el, input logic [7:0] eo);
    @(negedge core_clk);
    wave_valid = 1'b1;
    wave_sample = s;
    overdrive_valid = 1'b1;
    overdrive_level = o;
    @(negedge core_clk);
    wave_valid = 1'b0;
    overdrive_valid = 1'b0;
    `CHK(level_valid, 1'b1)
    `CHK(level_code, el)
    `CHK(od_valid, 1'b1)
    `CHK(od_level, eo)
    @(negedge core_clk);
    `CHK(drive_valid, 1'b1)
    `CHK(drive_level, {7'h00, el, 1'b0})
    `CHK(seen_od, eo)
  endtask : wave

  initial begin
    repeat (10) @(negedge core_clk);
    rstn = 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(8'h0a + 8'(i), RST_TAB[i]);
    end
    `CHK(resonant_period_value, 15'h10cf)
    `CHK(voltage_current_factor, 16'h010d)
    $display("reset values test done");
    // short period: two units of 66.666 cycles each, phase high in the second
    wr(8'h0a, 8'h00);
    wr(8'h0b, 8'h02);
    n = 0;
    while (period_pulse !== 1'b1 && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
    `CHK(drive_phase, 1'b0)
    n = 0;
    m = 0;
    do begin
      @(negedge core_clk);
      n++;
      if (drive_phase === 1'b1) begin
        m++;
      end
    end while (period_pulse !== 1'b1 && n < 1000);
    `CHK((n == 133) || (n == 134), 1'b1)
    `CHK((m == 66) || (m == 67), 1'b1)
    `CHK(pulses > 0, 1'b1)
    $display("period timer test done");
    for (int i = 0; i < 9; i++) begin
      wr(8'h0a + 8'(i), 8'ha5);
    end
    wr(8'h20, 8'ha5);
    for (int i = 0; i < 9; i++) begin
      rd(8'h0a + 8'(i), PAT_TAB[i]);
    end
    rd(8'h20, 8'h00);
    `CHK(resonant_period_value, 15'h52a5)
    `CHK(voltage_current_factor, 16'ha5a5)
    `CHK(max_current_code, 5'h05)
    $display("register access test done");
    @(negedge core_clk);
    imp_update = 1'b1;
    imp_value = 10'h161;
    @(negedge core_clk);
    imp_update = 1'b0;
    rd(8'h11, 8'h58);
    rd(8'h12, 8'h01);
    $display("impedance test done");
    // factor 0x0200 doubles each level on the drive output
    wr(8'h0c, 8'h40);
    wr(8'h0d, 8'h80);
    wr(8'h0f, 8'h02);
    wr(8'h10, 8'h00);
    accel_en = 1'b1;
    @(negedge core_clk);
    `CHK(full_scale_code, 8'h40)
    wave(8'hff, 8'ha0, 8'h40, 8'h80);
    wave(8'h7f, 8'h30, 8'h20, 8'h30);
    accel_en = 1'b0;
    @(negedge core_clk);
    `CHK(full_scale_code, 8'h80)
    wave(8'hff, 8'ha0, 8'h80, 8'ha0);
    // the actuator latches the drive level one edge after drive_valid
    @(negedge core_clk);
    `CHK(seen_drive, 16'h0100)
    $display("scaling test done");
    tally_and_finish();
  end
endmodule : haptic_actuator_config_regs_tb
